// ---- include/pack_prot_pkg.sv ----
`default_nettype none
package pack_prot_pkg;
	// temperatures are signed, 0.1 degC per lsb
	localparam int TW = 16;
	localparam int NSTG = 8;
	localparam int CLK_HZ = 125_000_000;
	localparam int CTRL_PERIOD_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * CTRL_PERIOD_S;
	localparam logic [11:0] SEC_PER_HOUR = 12'hE10;
	localparam logic [7:0] NODE_DASH = 8'hFF;
	localparam logic [10:0] PCT_FULL = 11'h064;
	localparam logic [10:0] CAP_MIN_PCT = 11'h028;
	localparam logic [1:0] CASCADE_PRIO = 2'h2;
	localparam int DT_SHIFT = 2;
	typedef struct packed {
		logic signed [TW-1:0] shutdown;
		logic signed [TW-1:0] enable;
		logic signed [TW-1:0] cutoff;
		logic signed [TW-1:0] setpoint;
		logic signed [TW-1:0] nz;
	} limits_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] node;
		logic       positive;
	} cascade_ack_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] node;
	} cascade_demand_t;
endpackage : pack_prot_pkg
`default_nettype wire

// ---- logic/compressor_pack_protection.sv ----
`timescale 1ns/1ps
`default_nettype none
module compressor_pack_protection #(
	parameter int TICK_CYCLES = pack_prot_pkg::TICK_CYCLES
) (
	input  wire logic                         sys_clk,
	input  wire logic                         rstn,
	input  wire logic                         high_side_contact_ok,
	input  wire logic                         low_side_contact_ok,
	input  wire pack_prot_pkg::limits_t       limits,
	input  wire logic signed [15:0]           condensing_temp,
	input  wire logic signed [15:0]           suction_temp,
	input  wire logic [3:0]                   stage_count,
	input  wire logic [3:0]                   stage_demand,
	input  wire logic [15:0]                  unload_time,
	input  wire logic [15:0]                  high_condensing_report_delay,
	input  wire logic [15:0]                  suction_alarm_delay,
	input  wire logic [1:0]                   trip_priority,
	input  wire logic [1:0]                   suction_priority,
	input  wire logic                         heat_recovery,
	input  wire logic                         freezer_side_pack,
	input  wire logic                         co2_refrigerant,
	input  wire logic [7:0]                   cascade_partner_first,
	input  wire logic [7:0]                   cascade_partner_second,
	input  wire logic [7:0]                   ack_timeout,
	input  wire logic [7:0]                   starts_per_hour,
	input  wire logic                         variable_speed,
	input  wire logic                         fc_fault,
	input  wire pack_prot_pkg::cascade_ack_t  ack,
	output pack_prot_pkg::cascade_demand_t    demand,
	output logic [7:0]                        stage_on,
	output logic                              high_side_trip_alarm,
	output logic [1:0]                        high_side_trip_priority,
	output logic                              high_condensing_report,
	output logic                              suction_low_alarm,
	output logic [1:0]                        suction_alarm_priority,
	output logic                              excess_start_alarm,
	output logic [1:0]                        cascade_fault,
	output logic [1:0]                        cascade_fault_priority
);
	localparam int NS = pack_prot_pkg::NSTG;
	logic [1:0] hp_sync, lp_sync;
	logic [26:0] tcnt, next_tcnt;
	logic tick;
	logic signed [15:0] span, dt, high_lim, warm_lim;
	logic hp_trip, lp_trip, force_off, block, cap_ok, space_ok, en;
	logic [11:0] interval;
	logic [3:0] act, next_act;
	logic [15:0] ut, next_ut, hc_cnt, next_hc_cnt, sa_cnt, next_sa_cnt;
	logic unloading, next_unloading, shut_latch, next_shut_latch;
	logic low_cut, next_low_cut;
	logic [11:0] sp [NS], next_sp [NS];
	logic [11:0] hour, next_hour;
	logic [7:0] starts, next_starts;
	logic [1:0] dem, next_dem, pend, next_pend, outst, next_outst;
	logic [1:0] pvalid, next_fault;
	logic [7:0] pnode [2];
	logic [7:0] wt [2], next_wt [2];
	pack_prot_pkg::cascade_demand_t next_demand;

	// contacts are pins: two flops before anything reads them
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			hp_sync <= 2'h0;
			lp_sync <= 2'h0;
		end else begin
			hp_sync <= {hp_sync[0], high_side_contact_ok};
			lp_sync <= {lp_sync[0], low_side_contact_ok};
		end
	end

	always_comb begin
		next_tcnt = tcnt + 27'h1;
		if (tcnt == 27'(TICK_CYCLES - 1))
			next_tcnt = 27'h0;
	end
	assign tick = (tcnt == 27'(TICK_CYCLES - 1));

	assign hp_trip = !hp_sync[1];
	assign lp_trip = !lp_sync[1];
	assign span = limits.shutdown - limits.enable;
	assign dt = span >>> pack_prot_pkg::DT_SHIFT;
	assign high_lim = limits.shutdown - dt;
	assign warm_lim = limits.setpoint + (limits.nz >>> 1);
	assign force_off = hp_trip || lp_trip || low_cut;
	assign block = (condensing_temp > high_lim) || shut_latch;
	// a further unload must leave at least 40 percent of the pack running
	assign cap_ok = (11'(act - 4'h1) * pack_prot_pkg::PCT_FULL) >=
		(11'(stage_count) * pack_prot_pkg::CAP_MIN_PCT);
	// hardware divider; settles well inside one tick
	assign interval = (starts_per_hour == 8'h0) ? 12'h0 :
		12'(pack_prot_pkg::SEC_PER_HOUR / starts_per_hour);
	// spacing is bypassed only for a healthy frequency changer
	assign space_ok = (variable_speed && !fc_fault) ||
		(act < 4'(NS) && sp[act[2:0]] == 12'h0);

	always_comb begin
		next_act = act;
		next_ut = ut;
		next_unloading = unloading;
		next_shut_latch = shut_latch;
		next_low_cut = low_cut;
		next_hc_cnt = hc_cnt;
		next_sa_cnt = sa_cnt;
		next_hour = hour;
		next_starts = starts;
		for (int i = 0; i < NS; i++)
			next_sp[i] = sp[i];
		if (tick) begin
			for (int i = 0; i < NS; i++)
				if (sp[i] != 12'h0)
					next_sp[i] = sp[i] - 12'h1;
			if (condensing_temp >= limits.shutdown)
				next_shut_latch = 1'b1;
			else if (condensing_temp < limits.enable)
				next_shut_latch = 1'b0;
			if (suction_temp < limits.cutoff)
				next_low_cut = 1'b1;
			else if (suction_temp >= warm_lim)
				next_low_cut = 1'b0;
			if (condensing_temp > high_lim && !heat_recovery) begin
				if (hc_cnt != 16'hFFFF)
					next_hc_cnt = hc_cnt + 16'h1;
			end else
				next_hc_cnt = 16'h0;
			if (suction_temp < limits.cutoff) begin
				if (sa_cnt != 16'hFFFF)
					next_sa_cnt = sa_cnt + 16'h1;
			end else
				next_sa_cnt = 16'h0;
			next_hour = hour + 12'h1;
			if (hour == pack_prot_pkg::SEC_PER_HOUR - 12'h1) begin
				next_hour = 12'h0;
				next_starts = 8'h0;
			end
			if (ut != 16'hFFFF)
				next_ut = ut + 16'h1;
			if (force_off) begin
				next_act = 4'h0;
				next_unloading = 1'b0;
			end else if (condensing_temp >= limits.shutdown &&
				act != 4'h0) begin
				if (!unloading) begin
					next_act = act - 4'h1;
					next_ut = 16'h0;
					next_unloading = 1'b1;
				end else if (ut >= unload_time && cap_ok) begin
					next_act = act - 4'h1;
					next_ut = 16'h0;
				end
			end else begin
				next_unloading = 1'b0;
				// one stage per tick gives the stagewise restart
				if (act < stage_demand && act < stage_count &&
					!block && space_ok) begin
					next_act = act + 4'h1;
					next_sp[act[2:0]] = interval;
					if (starts != 8'hFF)
						next_starts = starts + 8'h1;
				end
			end
		end
	end

	assign pnode[0] = cascade_partner_first;
	assign pnode[1] = cascade_partner_second;
	assign pvalid[0] = cascade_partner_first != pack_prot_pkg::NODE_DASH;
	assign pvalid[1] = cascade_partner_second != pack_prot_pkg::NODE_DASH &&
		cascade_partner_second != cascade_partner_first;
	assign en = freezer_side_pack && co2_refrigerant && (|pvalid);

	always_comb begin
		next_dem = dem;
		next_pend = pend;
		next_outst = outst;
		next_fault = cascade_fault;
		next_demand = '{valid: 1'b0, node: demand.node};
		for (int p = 0; p < 2; p++)
			next_wt[p] = wt[p];
		if (tick) begin
			if (condensing_temp > limits.shutdown - (dt <<< 1))
				next_dem[0] = 1'b1;
			else if (condensing_temp < limits.enable + dt)
				next_dem[0] = 1'b0;
			if (condensing_temp > high_lim)
				next_dem[1] = 1'b1;
			else if (condensing_temp < limits.enable)
				next_dem[1] = 1'b0;
			for (int p = 0; p < 2; p++) begin
				if (next_dem[p] && pvalid[p])
					next_pend[p] = 1'b1;
				if (outst[p]) begin
					next_wt[p] = wt[p] + 8'h1;
					if (wt[p] + 8'h1 >= ack_timeout)
						next_fault[p] = 1'b1;
				end
			end
		end
		// both partners due in one tick go out on consecutive cycles
		if (pend[0]) begin
			next_pend[0] = 1'b0;
			next_outst[0] = 1'b1;
			next_demand = '{valid: 1'b1, node: pnode[0]};
		end else if (pend[1]) begin
			next_pend[1] = 1'b0;
			next_outst[1] = 1'b1;
			next_demand = '{valid: 1'b1, node: pnode[1]};
		end
		for (int p = 0; p < 2; p++)
			if (ack.valid && pvalid[p] && ack.node == pnode[p]) begin
				next_outst[p] = 1'b0;
				next_wt[p] = 8'h0;
				next_fault[p] = !ack.positive;
			end
		if (!en) begin
			next_dem = 2'h0;
			next_pend = 2'h0;
			next_outst = 2'h0;
			next_fault = 2'h0;
			next_demand.valid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tcnt <= 27'h0;
			act <= 4'h0;
			ut <= 16'h0;
			unloading <= 1'b0;
			shut_latch <= 1'b0;
			low_cut <= 1'b0;
			hc_cnt <= 16'h0;
			sa_cnt <= 16'h0;
			hour <= 12'h0;
			starts <= 8'h0;
			for (int i = 0; i < NS; i++)
				sp[i] <= 12'h0;
			dem <= 2'h0;
			pend <= 2'h0;
			outst <= 2'h0;
			cascade_fault <= 2'h0;
			wt[0] <= 8'h0;
			wt[1] <= 8'h0;
			demand <= '{valid: 1'b0, node: 8'h0};
			stage_on <= 8'h0;
			high_side_trip_alarm <= 1'b0;
			high_side_trip_priority <= 2'h0;
			high_condensing_report <= 1'b0;
			suction_low_alarm <= 1'b0;
			suction_alarm_priority <= 2'h0;
			excess_start_alarm <= 1'b0;
			cascade_fault_priority <= 2'h0;
		end else begin
			tcnt <= next_tcnt;
			act <= next_act;
			ut <= next_ut;
			unloading <= next_unloading;
			shut_latch <= next_shut_latch;
			low_cut <= next_low_cut;
			hc_cnt <= next_hc_cnt;
			sa_cnt <= next_sa_cnt;
			hour <= next_hour;
			starts <= next_starts;
			sp <= next_sp;
			dem <= next_dem;
			pend <= next_pend;
			outst <= next_outst;
			cascade_fault <= next_fault;
			wt <= next_wt;
			demand <= next_demand;
			stage_on <= 8'((16'h1 << act) - 16'h1);
			high_side_trip_alarm <= hp_trip;
			high_side_trip_priority <= trip_priority;
			high_condensing_report <= !heat_recovery && hc_cnt != 16'h0 &&
				hc_cnt >= high_condensing_report_delay;
			suction_low_alarm <= sa_cnt != 16'h0 &&
				sa_cnt >= suction_alarm_delay;
			suction_alarm_priority <= suction_priority;
			excess_start_alarm <= variable_speed &&
				starts > starts_per_hour;
			cascade_fault_priority <= pack_prot_pkg::CASCADE_PRIO;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_trip_seen;
		tick && hp_trip;
	endsequence
	property p_trip_off;
		s_trip_seen |=> act == 4'h0;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("trip kept stages");
	property p_restage_one;
		tick |=> act <= $past(act) + 4'h1;
	endproperty
	a_restage_one: assert property (p_restage_one) else $error("multi load");
	property p_no_load_hot;
		tick && block |=> act <= $past(act);
	endproperty
	a_no_load_hot: assert property (p_no_load_hot) else $error("loaded hot");
	property p_no_report_hr;
		heat_recovery |=> !high_condensing_report;
	endproperty
	a_no_report_hr: assert property (p_no_report_hr) else $error("report hr");
	property p_first_unload;
		tick && !force_off && !unloading && act != 4'h0 &&
			condensing_temp >= limits.shutdown |=> act == $past(act) - 4'h1;
	endproperty
	a_first_unload: assert property (p_first_unload) else $error("no unload");
	property p_lp_off;
		tick && lp_trip |=> act == 4'h0;
	endproperty
	a_lp_off: assert property (p_lp_off) else $error("lp kept stages");
	property p_inactive;
		!en ##1 !en |-> !demand.valid && cascade_fault == 2'h0;
	endproperty
	a_inactive: assert property (p_inactive) else $error("cascade active");
	property p_neg_ack;
		en && ack.valid && pvalid[0] && ack.node == pnode[0] &&
			!ack.positive |=> cascade_fault[0];
	endproperty
	a_neg_ack: assert property (p_neg_ack) else $error("nack lost");
	property p_demand_one;
		demand.valid |=> !demand.valid || $past(pend[1]);
	endproperty
	a_demand_one: assert property (p_demand_one) else $error("burst");
endmodule : compressor_pack_protection
`default_nettype wire

// ---- tb/cascade_partner_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cascade_partner_model (
	input  wire logic                           sys_clk,
	input  wire logic                           rstn,
	input  wire pack_prot_pkg::cascade_demand_t demand,
	input  wire logic [1:0]                     mode,
	input  wire logic [3:0]                     lat,
	input  wire logic                           warm,
	output pack_prot_pkg::cascade_ack_t         ack
);
	// mode 0 answers normally, 1 cannot load, 2 stays silent
	pack_prot_pkg::cascade_demand_t line [16];
	logic                           running;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			line <= '{default: '0};
			running <= 1'b0;
			ack <= '0;
		end else begin
			line[0] <= demand;
			for (int i = 1; i < 16; i++) begin
				line[i] <= line[i - 1];
			end
			// idle fields never repeat the last answer
			ack <= '{1'b0, ~ack.node, ~ack.positive};
			if (demand.valid && !running && warm && mode == 2'h0) begin
				running <= 1'b1;
			end else if (!warm) begin
				running <= 1'b0;
			end
			if (line[lat].valid && mode != 2'h2) begin
				ack <= '{1'b1, line[lat].node,
					mode == 2'h0 && (running || !warm)};
			end
		end
	end
endmodule : cascade_partner_model
`default_nettype wire

// ---- tb/compressor_pack_protection_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module compressor_pack_protection_tb;
	localparam int T = 16;
	logic                           sys_clk, rstn, hs_ok, ls_ok, hr, wm;
	logic                           fz, co2, vs, fcf, hta, hcr, sla, esa;
	logic signed [15:0]             tc, ts;
	logic [3:0]                     sc, sd, lat;
	logic [1:0]                     tp, sp, mode, htp, sap, cf, cfp;
	logic [7:0]                     p1, p2, son;
	pack_prot_pkg::limits_t         lim;
	pack_prot_pkg::cascade_ack_t    ack;
	pack_prot_pkg::cascade_demand_t dem;
	int                             error_cnt, num_checks, nd [2];
	compressor_pack_protection #(.TICK_CYCLES(T)) dut (.sys_clk, .rstn,
		.high_side_contact_ok(hs_ok), .low_side_contact_ok(ls_ok),
		.limits(lim), .condensing_temp(tc), .suction_temp(ts),
		.stage_count(sc), .stage_demand(sd), .unload_time(16'h0002),
		.high_condensing_report_delay(16'h0003),
		.suction_alarm_delay(16'h0003), .trip_priority(tp),
		.suction_priority(sp), .heat_recovery(hr), .freezer_side_pack(fz),
		.co2_refrigerant(co2), .cascade_partner_first(p1),
		.cascade_partner_second(p2), .ack_timeout(8'h03),
		.starts_per_hour(8'h00), .variable_speed(vs), .fc_fault(fcf),
		.ack, .demand(dem), .stage_on(son), .high_side_trip_alarm(hta),
		.high_side_trip_priority(htp), .high_condensing_report(hcr),
		.suction_low_alarm(sla), .suction_alarm_priority(sap),
		.excess_start_alarm(esa), .cascade_fault(cf),
		.cascade_fault_priority(cfp));
	cascade_partner_model pm (.sys_clk, .rstn, .demand(dem), .mode,
		.lat, .warm(wm), .ack);
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (dem.valid === 1'b1) begin
			if (dem.node === p1) nd[0]++;
			else if (dem.node === p2) nd[1]++;
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n * T) @(posedge sys_clk);
	endtask : ticks
	function automatic int floor_st(input int s);
		int m;
		m = s - 1;
		while (m > 1 && (m - 1) * 100 >= 40 * s) m--;
		return m;
	endfunction : floor_st
	function automatic int lvl(input int c);
		return c > 2 ? 2 : c > 0;
	endfunction : lvl
	// stages may come back one per tick and never all at once
	task automatic climb(input int n);
		int prev, c;
		prev = $countones(son);
		repeat (n + 1) begin
			ticks(1);
			c = $countones(son);
			chk("step", c >= prev && c - prev <= 1, 1);
			prev = c;
		end
		chk("stage_on", son, (1 << n) - 1);
	endtask : climb
	task automatic casc(input logic [15:0] v, input int e);
		tc <= v;
		lat <= 4'($urandom_range(9, 0));
		ticks(1);
		nd = '{0, 0};
		ticks(4);
		chk("demand_first", lvl(nd[0]), e / 10);
		chk("demand_second", lvl(nd[1]), e % 10);
	endtask : casc
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		$display("MISMATCH watchdog expected end seen hang");
		conclude();
	end
	initial begin
		int n, k;
		logic [7:0] a;
		lim = '{16'h0190, 16'h00C8, 16'hFED4, 16'hFF06, 16'h0028};
		{rstn, hr, fz, co2, vs, fcf, mode, lat} = '0;
		{hs_ok, ls_ok, wm} = 3'h7;
		tc = 16'h0064;
		ts = 16'hFF38;
		{sc, sd, tp, sp} = '0;
		{p1, p2} = 16'hFFFF;
		void'($urandom(32'hA355EB73));
		repeat (12) @(posedge sys_clk);
		n = $urandom_range(8, 3);
		rstn <= 1'b1;
		sc <= 4'(n);
		sd <= 4'(n);
		{tp, sp, vs, fcf} <= 6'($urandom);
		climb(n);
		chk("excess_start", esa, vs);
		for (k = 0; k < 2; k++) begin
			if (k == 0) hs_ok <= 1'b0;
			else ls_ok <= 1'b0;
			ticks(2);
			chk("stage_on", son, 0);
			chk("trip_alarm", {hta, htp}, {k == 0, tp});
			{hs_ok, ls_ok} <= 2'h3;
			climb(n);
		end
		$display("test contacts done");
		ts <= 16'hFECA;
		ticks(1);
		chk("suction_alarm", sla, 0);
		ticks(5);
		chk("stage_on", son, 0);
		chk("suction_alarm", {sla, sap}, {1'b1, sp});
		ts <= 16'hFF38;
		sd <= 4'h2;
		ticks(1);
		climb(2);
		$display("test suction done");
		tc <= 16'h0168;
		sd <= 4'(n);
		ticks(2);
		chk("stage_on", son, 8'h03);
		chk("report", hcr, 0);
		ticks(3);
		chk("report", hcr, 1);
		tc <= 16'h0064;
		ticks(n + 1);
		tc <= 16'h019A;
		ticks(1);
		repeat (4) @(posedge sys_clk);
		chk("first_unload", $countones(son), n - 1);
		ticks(2 * n + 2);
		chk("unload_floor", $countones(son), floor_st(n));
		tc <= 16'h012C;
		ticks(3);
		chk("load_block", $countones(son), floor_st(n));
		tc <= 16'h0064;
		ticks(n + 1);
		chk("stage_on", son, (1 << n) - 1);
		hr <= 1'b1;
		tc <= 16'h0168;
		ticks(6);
		chk("report", hcr, 0);
		hr <= 1'b0;
		$display("test condensing done");
		a = 8'($urandom_range(126, 0));
		{fz, co2, p1, p2} <= {2'h3, a, a + 8'h01};
		casc(16'h0136, 20);
		casc(16'h0168, 22);
		casc(16'h0154, 22);
		casc(16'h0104, 22);
		casc(16'h00F0, 2);
		casc(16'h0096, 0);
		tc <= 16'h0168;
		ticks(3);
		chk("fault", cf, 0);
		mode <= 2'h1;
		ticks(2);
		chk("fault", {cf, cfp}, 4'hE);
		mode <= 2'h0;
		wm <= 1'b0;
		ticks(2);
		chk("fault", cf, 0);
		mode <= 2'h2;
		ticks(2);
		chk("fault", cf, 0);
		ticks(3);
		chk("fault", cf, 3);
		mode <= 2'h0;
		wm <= 1'b1;
		p2 <= a;
		casc(16'h0096, 0);
		casc(16'h0168, 20);
		{p1, p2} <= 16'hFFFF;
		casc(16'h0096, 0);
		casc(16'h0168, 0);
		{p1, p2, co2} <= {a, a + 8'h01, 1'b0};
		casc(16'h0096, 0);
		casc(16'h0168, 0);
		$display("test cascade done");
		conclude();
	end
endmodule : compressor_pack_protection_tb
`default_nettype wire
